// file: hdl/tile_debug_status_regs.sv
// Purpose: processor status / debug register bank of one tile, AHB-Lite slave
// Assumes: core signals are synchronous to hclk; word access only
// Notes:   zero wait states; reads come straight from the register flops
//
// Function
// - four read-only 16-bit oscillator counts
// - oscillator counts not cleared by reset
// - read-only ram size, bits 31:2
// - capture saved status on debug entry
// - status bits 0-4 as defined
// - status bits 6-10 as defined
// - capture saved program counter on entry
// - capture saved stack pointer on entry
// - record three-bit debug interrupt cause
// - record causing thread, zero for host
// - watchpoint address or resource id stored
// - stop vector blocks threads outside debug
// - eight scratch words shared with config
// - four breakpoint addresses raise debug interrupt
// - oscillator enables in control bits 1,0
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module tile_debug_status_regs
  import tile_dbg_pkg::*;
#(
  parameter logic [31:0] RAM_SIZE = RAM_BYTES
)
(
  // clock and resets
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  por_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // oscillators
  input  wire logic [N_OSC-1:0]      osc_tick,
  output logic                       osc_core_en,
  output logic                       osc_periph_en,
  // core state
  input  wire logic                  in_debug,
  input  wire logic                  dbg_enter,
  input  wire logic [2:0]            enter_cause,
  input  wire logic [7:0]            enter_thread,
  input  wire logic [3:0]            enter_hits,
  input  wire logic [31:0]           enter_info,
  input  wire logic [SR_W-1:0]       enter_sr,
  input  wire logic [31:0]           enter_pc,
  input  wire logic [31:0]           enter_sp,
  // issuing pc for breakpoints
  input  wire logic                  pc_valid,
  input  wire logic [31:0]           pc,
  input  wire logic [2:0]            pc_thread,
  output logic                       ibrk_req,
  output logic [1:0]                 ibrk_idx,
  // core controls
  output logic [STOP_W-1:0]          thread_stop,
  output logic [RD_THREAD_W-1:0]     rd_thread_sel,
  output logic [RD_REG_W-1:0]        rd_reg_sel,
  // tile config scratch port
  input  wire logic                  cfg_scr_we,
  input  wire logic [2:0]            cfg_scr_idx,
  input  wire logic [31:0]           cfg_scr_wdata,
  output logic [31:0]                cfg_scr_rdata
);
  logic [7:0]            wr_idx_r;
  logic                  wr_pend_r;
  logic [7:0]            rd_idx_r;
  logic                  rd_pend_r;
  logic                  wr_ok;
  logic                  dbg_wr;
  logic [1:0]            osc_ctrl_r;
  logic [SR_W-1:0]       saved_sr_r;
  logic [31:0]           saved_pc_r;
  logic [31:0]           saved_sp_r;
  logic [2:0]            cause_code_r;
  logic [1:0]            cause_idx_r;
  logic [7:0]            cause_thread_r;
  logic [31:0]           irq_info_r;
  logic [STOP_W-1:0]     stop_vec_r;
  logic [31:0]           scratch_r [N_SCRATCH];
  logic [31:0]           ibrk_addr_r [N_IBRK];
  logic [31:0]           ibrk_ctrl_r [N_IBRK];
  logic [OSC_CNT_W-1:0]  osc_count [N_OSC];
  logic                  ibrk_hit;
  logic [1:0]            ibrk_hit_idx;
  logic [31:0]           rd_nxt;
  logic                  is_host;
  logic                  has_index;

  // address phase: any active transfer is accepted; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      rd_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= hsel && htrans[1] && hready && hwrite;
      rd_pend_r <= hsel && htrans[1] && hready && !hwrite;
      if (hsel && htrans[1] && hready) begin
        wr_idx_r <= haddr[9:2];
        rd_idx_r <= haddr[9:2];
      end
    end
  end

  // never stalls, never errors; unmapped reads return zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_ok     = wr_pend_r;
  assign dbg_wr    = wr_pend_r && in_debug;

  // oscillator control, writable at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) osc_ctrl_r <= RST_OSC;
    else if (wr_ok && wr_idx_r == IDX_OSC_CTRL) osc_ctrl_r <= hwdata[1:0];
  end
  assign osc_core_en   = osc_ctrl_r[OSC_CORE_EN_BIT];
  assign osc_periph_en = osc_ctrl_r[OSC_PERIPH_EN_BIT];

  // counters, tile pair on the core enable, periph pair on the other
  for (genvar g = 0; g < N_OSC; g++) begin : g_osc
    osc_counter u_cnt (
      .hclk  (hclk),
      .por_n (por_n),
      .run   (g < 2 ? osc_core_en : osc_periph_en),
      .tick  (osc_tick[g]),
      .count (osc_count[g])
    );
  end

  // debug entry decode
  assign is_host   = enter_cause == CAUSE_HOST;
  assign has_index = enter_cause inside {CAUSE_IBREAK, CAUSE_DWATCH, CAUSE_RWATCH};

  // entry capture beats a same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) saved_sr_r <= '0;
    else if (dbg_enter) saved_sr_r <= enter_sr & SR_CAPTURE_MASK;
    else if (dbg_wr && wr_idx_r == IDX_SAVED_SR)
      saved_sr_r <= (saved_sr_r & ~SR_WRITE_MASK) | (hwdata[SR_W-1:0] & SR_WRITE_MASK);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      saved_pc_r <= RST_WORD;
      saved_sp_r <= RST_WORD;
    end else if (dbg_enter) begin
      saved_pc_r <= enter_pc;
      saved_sp_r <= enter_sp;
    end else begin
      if (dbg_wr && wr_idx_r == IDX_SAVED_PC) saved_pc_r <= hwdata;
      if (dbg_wr && wr_idx_r == IDX_SAVED_SP) saved_sp_r <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_code_r   <= CAUSE_NONE;
      cause_idx_r    <= 2'h0;
      cause_thread_r <= 8'h00;
    end else if (dbg_enter) begin
      cause_code_r   <= enter_cause;
      cause_idx_r    <= has_index ? lowest_hit(enter_hits) : 2'h0;
      cause_thread_r <= is_host ? 8'h00 : enter_thread;
    end else if (dbg_wr && wr_idx_r == IDX_IRQ_CAUSE) begin
      cause_code_r   <= hwdata[CAUSE_CODE_LSB +: 3];
      cause_idx_r    <= hwdata[CAUSE_INDEX_LSB +: 2];
      cause_thread_r <= hwdata[CAUSE_THREAD_LSB +: 8];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_info_r <= RST_WORD;
    else if (dbg_enter && enter_cause inside {CAUSE_DWATCH, CAUSE_RWATCH})
      irq_info_r <= enter_info;
    else if (!dbg_enter && dbg_wr && wr_idx_r == IDX_IRQ_INFO) irq_info_r <= hwdata;
  end

  // operands for the debug register read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_thread_sel <= '0;
      rd_reg_sel    <= '0;
    end else begin
      if (dbg_wr && wr_idx_r == IDX_RD_THREAD) rd_thread_sel <= hwdata[RD_THREAD_W-1:0];
      if (dbg_wr && wr_idx_r == IDX_RD_REG) rd_reg_sel <= hwdata[RD_REG_W-1:0];
    end
  end

  // stop vector register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stop_vec_r <= '0;
    else if (dbg_wr && wr_idx_r == IDX_STOP_VEC) stop_vec_r <= hwdata[STOP_W-1:0];
  end

  // gated by debug mode, so stepping works
  assign thread_stop = in_debug ? '0 : stop_vec_r;

  // one store, two ports; bus write wins a clash
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_SCRATCH; i++) scratch_r[i] <= RST_WORD;
    end else if (dbg_wr && wr_idx_r >= IDX_SCRATCH_0 && wr_idx_r <= IDX_SCRATCH_7) begin
      scratch_r[wr_idx_r[2:0]] <= hwdata;
    end else if (cfg_scr_we) begin
      scratch_r[cfg_scr_idx] <= cfg_scr_wdata;
    end
  end
  assign cfg_scr_rdata = scratch_r[cfg_scr_idx];

  // breakpoint address and control words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_IBRK; i++) begin
        ibrk_addr_r[i] <= RST_WORD;
        ibrk_ctrl_r[i] <= RST_WORD;
      end
    end else if (dbg_wr) begin
      if (wr_idx_r >= IDX_IBRK_ADDR_0 && wr_idx_r <= IDX_IBRK_ADDR_3)
        ibrk_addr_r[wr_idx_r[1:0]] <= hwdata;
      if (wr_idx_r >= IDX_IBRK_CTRL_0 && wr_idx_r <= IDX_IBRK_CTRL_3)
        ibrk_ctrl_r[wr_idx_r[1:0]] <= hwdata & 32'h00FF_0001;
    end
  end

  ibrk_match u_match (
    .pc_valid  (pc_valid),
    .pc        (pc),
    .pc_thread (pc_thread),
    .addr      (ibrk_addr_r),
    .ctrl      (ibrk_ctrl_r),
    .hit       (ibrk_hit),
    .hit_idx   (ibrk_hit_idx)
  );

  // request pulse; the debugger itself is not re-trapped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ibrk_req <= 1'b0;
      ibrk_idx <= 2'h0;
    end else begin
      ibrk_req <= ibrk_hit && !in_debug;
      ibrk_idx <= ibrk_hit_idx;
    end
  end

  // read mux in data phase, so a write just before is already visible
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (rd_pend_r) begin
      if (rd_idx_r == IDX_OSC_CTRL) rd_nxt = {30'h0, osc_ctrl_r};
      else if (rd_idx_r >= IDX_OSC_FIRST && rd_idx_r <= IDX_OSC_LAST)
        rd_nxt = {16'h0000, osc_count[2'(rd_idx_r - IDX_OSC_FIRST)]};
      // ram size, low two bits reserved
      else if (rd_idx_r == IDX_RAM_SIZE) rd_nxt = {RAM_SIZE[31:2], 2'b00};
      else if (rd_idx_r == IDX_SAVED_SR) rd_nxt = {21'h0, saved_sr_r};
      else if (rd_idx_r == IDX_SAVED_PC) rd_nxt = saved_pc_r;
      else if (rd_idx_r == IDX_SAVED_SP) rd_nxt = saved_sp_r;
      else if (rd_idx_r == IDX_RD_THREAD) rd_nxt = {24'h0, rd_thread_sel};
      else if (rd_idx_r == IDX_RD_REG) rd_nxt = {27'h0, rd_reg_sel};
      else if (rd_idx_r == IDX_IRQ_CAUSE)
        rd_nxt = {14'h0, cause_idx_r, cause_thread_r, 5'h00, cause_code_r};
      else if (rd_idx_r == IDX_IRQ_INFO) rd_nxt = irq_info_r;
      else if (rd_idx_r == IDX_STOP_VEC) rd_nxt = {24'h0, stop_vec_r};
      else if (rd_idx_r >= IDX_SCRATCH_0 && rd_idx_r <= IDX_SCRATCH_7)
        rd_nxt = scratch_r[rd_idx_r[2:0]];
      else if (rd_idx_r >= IDX_IBRK_ADDR_0 && rd_idx_r <= IDX_IBRK_ADDR_3)
        rd_nxt = ibrk_addr_r[rd_idx_r[1:0]];
      else if (rd_idx_r >= IDX_IBRK_CTRL_0 && rd_idx_r <= IDX_IBRK_CTRL_3)
        rd_nxt = ibrk_ctrl_r[rd_idx_r[1:0]];
    end
  end
  assign hrdata = rd_nxt;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_entry_pc: assert property (dbg_enter |=> saved_pc_r == $past(enter_pc))
    else $error("saved pc not captured on entry");
  chk_entry_sp: assert property (dbg_enter |=> saved_sp_r == $past(enter_sp))
    else $error("saved sp not captured on entry");
  chk_entry_sr: assert property (
    dbg_enter |=> saved_sr_r == ($past(enter_sr) & SR_CAPTURE_MASK))
    else $error("saved status not captured on entry");
  chk_sr_reserved: assert property (saved_sr_r[5] == 1'b0)
    else $error("status reserved bit set");
  chk_sr_issue_ro: assert property (
    !dbg_enter |=> saved_sr_r[8] == $past(saved_sr_r[8]))
    else $error("issue mode bit changed by software");
  chk_host_thread: assert property (
    dbg_enter && enter_cause == CAUSE_HOST |=> cause_thread_r == 8'h00 && cause_idx_r == 2'h0)
    else $error("host cause left thread or index");
  chk_cause_code: assert property (dbg_enter |=> cause_code_r == $past(enter_cause))
    else $error("cause code wrong");
  chk_low_index: assert property (
    dbg_enter && enter_cause == CAUSE_IBREAK && enter_hits == 4'b0110 |=> cause_idx_r == 2'h1)
    else $error("lowest breakpoint index not taken");
  chk_stop_gate: assert property (
    thread_stop == (in_debug ? 8'h00 : stop_vec_r) && (!in_debug || thread_stop == 8'h00))
    else $error("thread stop not gated by debug");
  chk_wr_outside: assert property (
    wr_pend_r && !in_debug |=> $stable(stop_vec_r) && $stable(rd_reg_sel))
    else $error("debug field written outside debug");
  // system reset must leave the counts alone; only power-on may clear them
  chk_osc_keep: assert property (disable iff (!por_n)
    !hresetn |-> osc_count[0] == $past(osc_count[0]) && osc_count[3] == $past(osc_count[3]))
    else $error("oscillator count changed by system reset");
  chk_ram_read: assert property (
    rd_pend_r && rd_idx_r == IDX_RAM_SIZE |-> hrdata == {RAM_SIZE[31:2], 2'b00})
    else $error("ram size read wrong");
  chk_ibrk_pulse: assert property (
    ibrk_hit && !in_debug |=> ibrk_req ##1 (ibrk_req == $past(ibrk_hit && !in_debug)))
    else $error("breakpoint request missing");

  cov_entry_dwatch: cover property (dbg_enter && enter_cause == CAUSE_DWATCH);
  cov_ibrk_hit:     cover property (ibrk_req);
  cov_scratch_rd:   cover property (rd_pend_r && rd_idx_r == IDX_SCRATCH_7);
endmodule : tile_debug_status_regs

// file: common/tile_dbg_pkg.sv
// Purpose: shared constants for the tile debug status register bank
// Assumes: 32-bit register words, word index = byte address / 4
// Notes:   offsets are word indices; byte address is four times the index
package tile_dbg_pkg;
  // register word indices
  localparam logic [7:0] IDX_OSC_CTRL    = 8'h06;
  localparam logic [7:0] IDX_OSC_FIRST   = 8'h07;
  localparam logic [7:0] IDX_OSC_LAST    = 8'h0A;
  localparam logic [7:0] IDX_RAM_SIZE    = 8'h0C;
  localparam logic [7:0] IDX_SAVED_SR    = 8'h10;
  localparam logic [7:0] IDX_SAVED_PC    = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP    = 8'h12;
  localparam logic [7:0] IDX_RD_THREAD   = 8'h13;
  localparam logic [7:0] IDX_RD_REG      = 8'h14;
  localparam logic [7:0] IDX_IRQ_CAUSE   = 8'h15;
  localparam logic [7:0] IDX_IRQ_INFO    = 8'h16;
  localparam logic [7:0] IDX_STOP_VEC    = 8'h18;
  localparam logic [7:0] IDX_SCRATCH_0   = 8'h20;
  localparam logic [7:0] IDX_SCRATCH_7   = 8'h27;
  localparam logic [7:0] IDX_IBRK_ADDR_0 = 8'h30;
  localparam logic [7:0] IDX_IBRK_ADDR_3 = 8'h33;
  localparam logic [7:0] IDX_IBRK_CTRL_0 = 8'h40;
  localparam logic [7:0] IDX_IBRK_CTRL_3 = 8'h43;
  // field layout
  localparam int OSC_CORE_EN_BIT   = 1;
  localparam int OSC_PERIPH_EN_BIT = 0;
  localparam int OSC_CNT_W         = 16;
  localparam int SR_W              = 11;
  localparam logic [10:0] SR_CAPTURE_MASK = 11'h7DF;   // bit 5 reserved
  localparam logic [10:0] SR_WRITE_MASK   = 11'h6DF;   // bit 8 read-only too
  localparam int CAUSE_CODE_LSB    = 0;
  localparam int CAUSE_THREAD_LSB  = 8;
  localparam int CAUSE_INDEX_LSB   = 16;
  localparam int RD_THREAD_W       = 8;
  localparam int RD_REG_W          = 5;
  localparam int STOP_W            = 8;
  localparam int IBRK_EN_BIT       = 0;
  localparam int IBRK_MASK_LSB     = 16;
  localparam int N_SCRATCH         = 8;
  localparam int N_IBRK            = 4;
  localparam int N_OSC             = 4;
  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [1:0]  RST_OSC   = 2'h0;
  localparam logic [31:0] RAM_BYTES = 32'h0004_0000;
  // debug interrupt causes
  typedef enum logic [2:0] {
    CAUSE_NONE   = 3'b000,
    CAUSE_HOST   = 3'b001,
    CAUSE_DEBUG_CALL_INSTRUCTION  = 3'b010,
    CAUSE_IBREAK = 3'b011,
    CAUSE_DWATCH = 3'b100,
    CAUSE_RWATCH = 3'b101
  } cause_t;

  // lowest set bit of a four-bit hit vector
  function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hits[i]) idx = 2'(i);
    end
    return idx;
  endfunction : lowest_hit
endpackage : tile_dbg_pkg

// file: hdl/osc_counter.sv
// Purpose: one ring oscillator count readout
// Assumes: tick is synchronous to hclk, one pulse per oscillator period
// Notes:   cleared only by power-on, never by the system reset
`timescale 1ns/1ps
module osc_counter
  import tile_dbg_pkg::*;
(
  // clock and power-on reset
  input  wire logic                 hclk,
  input  wire logic                 por_n,
  // counting
  input  wire logic                 run,
  input  wire logic                 tick,
  output logic [OSC_CNT_W-1:0]      count
);
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) count <= '0;
    else if (run && tick) count <= count + 1'b1;
  end
endmodule : osc_counter

// file: hdl/ibrk_match.sv
// Purpose: compare the issuing pc against four breakpoint addresses
// Assumes: pc_thread selects one bit of each per-thread enable mask
// Notes:   lowest matching breakpoint is reported
`timescale 1ns/1ps
module ibrk_match
  import tile_dbg_pkg::*;
(
  // issuing instruction
  input  wire logic                 pc_valid,
  input  wire logic [31:0]          pc,
  input  wire logic [2:0]           pc_thread,
  // breakpoint setup
  input  wire logic [31:0]          addr [N_IBRK],
  input  wire logic [31:0]          ctrl [N_IBRK],
  // result
  output logic                      hit,
  output logic [1:0]                hit_idx
);
  logic [N_IBRK-1:0] hits;

  always_comb begin
    for (int i = 0; i < N_IBRK; i++) begin
      hits[i] = pc_valid && ctrl[i][IBRK_EN_BIT]
             && ctrl[i][IBRK_MASK_LSB + int'(pc_thread)] && (pc == addr[i]);
    end
  end

  assign hit     = |hits;
  assign hit_idx = lowest_hit(hits);
endmodule : ibrk_match

// file: sim/dbg_host_model.sv
// Purpose: debug host model, a single-word ahb-lite master
// Assumes: one slave, okay responses only, hsel held high
// Notes:   signals change only right after a rising edge
`timescale 1ns/1ps
module dbg_host_model (
  // clock
  input  wire logic        hclk,
  // master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // idle bus from time zero
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h5a5a_5a5a;
  end

  // one word; called just after a rising edge, no latency assumed
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? wd : ~hwdata; // unused data never holds its value
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : dbg_host_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the tile debug status bank
// Assumes: zero-wait slave, core side driven by the bench
// Notes:   expectations come from bench literals, package masks and the cause_word function
`timescale 1ns/1ps
module tb_top;
  import tile_dbg_pkg::*;
  localparam logic [31:0] RAM_SZ = 32'h0002_0000;
  logic hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, enter_info = '0, enter_pc = '0, enter_sp = '0;
  logic [31:0] pc = '0, cfg_scr_wdata = '0, cfg_scr_rdata, dummy;
  logic [1:0] htrans, ibrk_idx;
  logic [2:0] hsize, enter_cause = '0, pc_thread = '0, cfg_scr_idx = '0;
  logic [3:0] osc_tick = '0, enter_hits = '0;
  logic [7:0] enter_thread = '0, thread_stop, rd_thread_sel;
  logic [10:0] enter_sr = '0;
  logic [4:0] rd_reg_sel;
  logic osc_core_en, osc_periph_en, ibrk_req, in_debug = 1'b0, dbg_enter = 1'b0;
  logic pc_valid = 1'b0, cfg_scr_we = 1'b0;
  int failures = 0, cmp_count = 0;

  tile_debug_status_regs #(.RAM_SIZE(RAM_SZ)) dut (.*, .hready(hreadyout));
  dbg_host_model host (.*, .hready(hreadyout));

  // 40 mhz clock
  always #12.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, dummy);
  endtask : wr

  task automatic rdx(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    host.xfer(1'b0, idx, 32'h0, v);
    chk(v, exp);
  endtask : rdx

  // expected cause word: lowest hit only for breakpoint and watchpoint causes (3 to 5)
  function automatic logic [31:0] cause_word(int c, logic [7:0] th, logic [3:0] h);
    logic [1:0] ix;
    ix = 2'h0;
    for (int i = 3; i >= 0; i--) if (h[i]) ix = 2'(i);
    if (c < 3) ix = 2'h0;
    if (c == 1) th = 8'h0;
    return {14'h0, ix, th, 5'h0, 3'(c)};
  endfunction : cause_word

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic test_osc();
    int cnt [4] = '{default: 0};
    logic [3:0] t;
    rdx(IDX_RAM_SIZE, RAM_SZ);
    wr(IDX_RAM_SIZE, 32'hffff_ffff);
    rdx(IDX_RAM_SIZE, RAM_SZ);
    rdx(8'h0b, 32'h0000_0000);
    rdx(IDX_OSC_CTRL, 32'h0000_0000);
    wr(IDX_OSC_CTRL, 32'h0000_0003);
    repeat (60) begin
      t = 4'($urandom);
      osc_tick <= t;
      @(posedge hclk);
      for (int i = 0; i < 4; i++) cnt[i] += int'(t[i]);
    end
    osc_tick <= 4'h0;
    chk({30'h0, osc_core_en, osc_periph_en}, 32'h0000_0003);
    wr(IDX_OSC_CTRL, 32'h0000_0000);
    // counts read only after a settled stop
    repeat (10) @(posedge hclk);
    for (int i = 0; i < 4; i++) rdx(8'(IDX_OSC_FIRST + i), 32'(cnt[i]));
    // enables set again so the reset really has something to clear
    wr(IDX_OSC_CTRL, 32'h0000_0003);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 4; i++) rdx(8'(IDX_OSC_FIRST + i), 32'(cnt[i]));
    chk({30'h0, osc_core_en, osc_periph_en}, 32'h0);
    $display("test osc done");
  endtask : test_osc

  task automatic test_entry();
    logic [31:0] p, s, inf, info;
    logic [10:0] sr;
    logic [7:0] th;
    logic [3:0] h;
    info = RST_WORD;
    for (int c = 1; c <= 5; c++) begin
      p = $urandom;
      s = $urandom;
      inf = $urandom;
      sr = 11'($urandom);
      th = 8'($urandom);
      h = 4'($urandom);
      in_debug <= 1'b1;
      dbg_enter <= 1'b1;
      enter_cause <= 3'(c);
      {enter_thread, enter_hits, enter_info} <= {th, h, inf};
      {enter_sr, enter_pc, enter_sp} <= {sr, p, s};
      @(posedge hclk);
      dbg_enter <= 1'b0;
      enter_pc <= ~p;
      if (c >= 4) info = inf;
      rdx(IDX_SAVED_SR, {21'h0, sr & SR_CAPTURE_MASK});
      rdx(IDX_SAVED_PC, p);
      rdx(IDX_SAVED_SP, s);
      rdx(IDX_IRQ_CAUSE, cause_word(c, th, h));
      rdx(IDX_IRQ_INFO, info);
    end
    // software rewrite in debug: issue mode bit and reserved bit keep their values
    wr(IDX_SAVED_SR, {21'h0, ~sr});
    rdx(IDX_SAVED_SR, {21'h0, (~sr & SR_WRITE_MASK) | (sr & SR_CAPTURE_MASK & 11'h100)});
    $display("test entry done");
  endtask : test_entry

  task automatic test_regs();
    logic [31:0] v, a [4];
    // operands written before a thread read
    wr(IDX_RD_THREAD, 32'hffff_ffa5);
    wr(IDX_RD_REG, 32'hffff_fff3);
    rdx(IDX_RD_THREAD, 32'h0000_00a5);
    rdx(IDX_RD_REG, 32'h0000_0013);
    chk({19'h0, rd_reg_sel, rd_thread_sel}, 32'h0000_13a5);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(8'(IDX_SCRATCH_0 + i), v);
      cfg_scr_idx <= 3'(i);
      @(negedge hclk);
      chk(cfg_scr_rdata, v);
      @(posedge hclk);
      {cfg_scr_we, cfg_scr_wdata} <= {1'b1, ~v};
      @(posedge hclk);
      cfg_scr_we <= 1'b0;
      rdx(8'(IDX_SCRATCH_0 + i), ~v);
    end
    wr(IDX_SAVED_PC, 32'h1234_5678);
    v = $urandom;
    wr(IDX_STOP_VEC, v);
    rdx(IDX_STOP_VEC, {24'h0, v[7:0]});
    chk({24'h0, thread_stop}, 32'h0);
    for (int i = 0; i < 4; i++) a[i] = $urandom;
    a[3] = a[1];
    for (int i = 0; i < 4; i++) wr(8'(IDX_IBRK_ADDR_0 + i), a[i]);
    for (int i = 0; i < 4; i++) wr(8'(IDX_IBRK_CTRL_0 + i), 32'h00ff_0001);
    rdx(IDX_IBRK_ADDR_0 + 8'h2, a[2]);
    in_debug <= 1'b0;
    @(negedge hclk);
    chk({24'h0, thread_stop}, {24'h0, v[7:0]});
    @(posedge hclk);
    wr(IDX_SAVED_PC, 32'hdead_0001);
    rdx(IDX_SAVED_PC, 32'h1234_5678);
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    // a[1] also at slot 3: lowest index must win
    for (int k = 0; k < 4; k++) begin
      {pc_valid, pc, pc_thread} <= {1'b1, (k == 3) ? ~a[0] : a[k], 3'($urandom)};
      @(posedge hclk);
      pc_valid <= 1'b0;
      @(negedge hclk);
      chk({30'h0, ibrk_req, ibrk_idx}, (k == 3) ? 32'h0 : 32'(4 + k));
      @(posedge hclk);
    end
    $display("test regs done");
  endtask : test_regs

  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    report_and_stop();
  end

  initial begin
    dummy = $urandom(32'hf49089f2);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    test_osc();
    test_entry();
    test_regs();
    report_and_stop();
  end
endmodule : tb_top
